// ==== tol_top.sv ====
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module tol_top import tol_pkg::*; #(
   parameter logic [CNT_W-1:0] TICK_CYCLES = CNT_W'(TICK_CYC),
   parameter logic [CNT_W-1:0] MDT_CYCLES = CNT_W'(MDT_CYC)
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic [NUM_ELEM-1:0] ELEM_OP,
   input wire logic [NUM_ELEM-1:0] FUNC_LOGIC,
   input wire logic [NUM_PHASE-1:0] CUR_LOW,
   input wire logic BREAKER_CLOSED_AUX,
   input wire logic BREAKER_OPEN_AUX,
   input wire logic [NUM_PIN-1:0] PIN_POS,
   input wire logic PIN6_NEG,
   input wire logic [NUM_SIG-1:0] LOGIC_SIG,
   output logic TRIP_CONTACT,
   output logic [NUM_OUT-1:0] OUT_CONTACT,
   output logic [NUM_PIN-1:0] PIN_STATE,
   output logic [NUM_ELEM-1:0] FUNC_EN
);
   // bus state
   tol_bus_e bus_reg;
   logic wr_pend_reg;
   logic [7:0] addr_reg;
   logic [31:0] hrdata_reg;
   logic hready_reg;
   // configuration
   logic [NUM_ELEM-1:0] mask_reg;
   logic [CTRL_W-1:0] ctrl_reg;
   logic [NUM_OUT-1:0] gate_reg;
   logic [NUM_SIG-1:0] map_reg [NUM_OUT];
   logic [DLY_W-1:0] pu_reg [NUM_OUT];
   logic [DLY_W-1:0] dr_reg [NUM_OUT];
   // protection state
   logic trip_reg;
   logic [CNT_W-1:0] mdt_cnt_reg;
   logic [CNT_W-1:0] tick_cnt_reg;
   logic tick_reg;
   logic [NUM_ELEM-1:0] func_en_reg;
   logic [NUM_PIN-1:0] pin_reg;
   logic trip_out_reg;
   logic [NUM_OUT-1:0] out_reg;
   logic [NUM_OUT-1:0] out_act;
   logic [NUM_OUT-1:0] comb;

   // address phase decode
   wire logic addr_ok = HSEL && HREADY && HTRANS[1];
   wire logic rd_req = addr_ok && !HWRITE;
   wire logic [2:0] grp = addr_reg[7:5];
   wire logic [2:0] idx = addr_reg[4:2];
   wire logic idx_ok = (idx < 3'(NUM_OUT)) && (addr_reg[1:0] == 2'b00);
   wire logic wr_mask = wr_pend_reg && addr_reg == OFF_MASK;
   wire logic wr_ctrl = wr_pend_reg && addr_reg == OFF_CTRL;
   wire logic wr_gate = wr_pend_reg && addr_reg == OFF_GATE;
   wire logic wr_arr = wr_pend_reg && idx_ok;
   wire logic [DLY_W-1:0] dly_wr = (HWDATA[DLY_W-1:0] > DLY_W'(DLY_MAX_TICKS)) ?
                                   DLY_W'(DLY_MAX_TICKS) : HWDATA[DLY_W-1:0];
   wire tol_bus_e bus_next = rd_req ? BUS_READ : BUS_IDLE;

   // read data selection
   wire logic [31:0] stat_word = {19'h0_0000, pin_reg, out_act, trip_reg};
   wire logic [31:0] fixed_rd = (addr_reg == OFF_MASK) ? 32'(mask_reg) :
                                (addr_reg == OFF_CTRL) ? 32'(ctrl_reg) :
                                (addr_reg == OFF_GATE) ? 32'(gate_reg) :
                                (addr_reg == OFF_STAT) ? stat_word : 32'h0000_0000;
   wire logic [31:0] arr_rd = !idx_ok ? 32'h0000_0000 :
                              (grp == GRP_MAP) ? 32'(map_reg[idx]) :
                              (grp == GRP_PICKUP) ? 32'(pu_reg[idx]) :
                              (grp == GRP_DROPOUT) ? 32'(dr_reg[idx]) : 32'h0000_0000;
   wire logic [31:0] rd_data = (grp == GRP_FIXED) ? fixed_rd : arr_rd;

   // bus handshake: writes zero wait, reads one wait
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         bus_reg <= BUS_IDLE;
         wr_pend_reg <= 1'b0;
         addr_reg <= 8'h00;
         hready_reg <= 1'b1;
      end else begin
         bus_reg <= bus_next;
         wr_pend_reg <= addr_ok && HWRITE;
         addr_reg <= addr_ok ? HADDR[7:0] : addr_reg;
         hready_reg <= (bus_next == BUS_IDLE);
      end
   end

   // read data register
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (bus_reg == BUS_READ) begin
         hrdata_reg <= rd_data;
      end
   end

   assign HRDATA = hrdata_reg;
   assign HREADYOUT = hready_reg;
   assign HRESP = 1'b0;

   // fixed configuration registers
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         mask_reg <= MASK_RST;
         ctrl_reg <= CTRL_RST;
         gate_reg <= GATE_RST;
      end else begin
         mask_reg <= wr_mask ? HWDATA[NUM_ELEM-1:0] : mask_reg;
         ctrl_reg <= wr_ctrl ? HWDATA[CTRL_W-1:0] : ctrl_reg;
         gate_reg <= wr_gate ? HWDATA[NUM_OUT-1:0] : gate_reg;
      end
   end

   // per-output mapping and timer settings
   always_ff @(posedge CLK) begin
      for (int i = 0; i < NUM_OUT; i++) begin
         if (!RST_B) begin
            map_reg[i] <= MAP_RST;
            pu_reg[i] <= DLY_RST;
            dr_reg[i] <= DLY_RST;
         end else if (wr_arr && idx == 3'(i)) begin
            if (grp == GRP_MAP) map_reg[i] <= HWDATA[NUM_SIG-1:0];
            if (grp == GRP_PICKUP) pu_reg[i] <= dly_wr;
            if (grp == GRP_DROPOUT) dr_reg[i] <= dly_wr;
         end
      end
   end

   // 10 ms time base
   wire logic tick_wrap = (tick_cnt_reg >= TICK_CYCLES - 24'h00_0001);
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         tick_cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         tick_cnt_reg <= tick_wrap ? '0 : tick_cnt_reg + 24'h00_0001;
         tick_reg <= tick_wrap;
      end
   end

   // physical inputs and function enables
   wire logic [NUM_PIN-1:0] pin_next = {PIN_POS[5] & PIN6_NEG, PIN_POS[4:0]};
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         pin_reg <= '0;
         func_en_reg <= '0;
      end else begin
         pin_reg <= pin_next;
         func_en_reg <= FUNC_LOGIC;
      end
   end
   assign PIN_STATE = pin_reg;
   assign FUNC_EN = func_en_reg;

   // master trip seal-in and release
   wire logic mdt = ctrl_reg[CTRL_MDT];
   wire logic all_low = &CUR_LOW;
   wire logic trip_set = |(ELEM_OP & mask_reg & func_en_reg);
   wire logic brk_open = BREAKER_OPEN_AUX && !BREAKER_CLOSED_AUX;
   wire logic release_ok = all_low && brk_open;
   wire logic mdt_done = all_low && (mdt_cnt_reg >= MDT_CYCLES - 24'h00_0001);
   wire logic trip_drop = mdt ? mdt_done : release_ok;
   wire logic trip_next = trip_set || (trip_reg && !trip_drop);
   wire logic [CNT_W-1:0] mdt_cnt_next = (trip_reg && mdt && all_low) ?
                                          mdt_cnt_reg + 24'h00_0001 : '0;
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         trip_reg <= 1'b0;
         mdt_cnt_reg <= '0;
      end else begin
         trip_reg <= trip_next;
         mdt_cnt_reg <= mdt_cnt_next;
      end
   end

   // programmable output gates and delay timers
   generate
      for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
         tol_tmr_if tif ();
         wire logic [NUM_SIG-1:0] hit = LOGIC_SIG & map_reg[g];
         assign comb[g] = gate_reg[g] ? ((hit == map_reg[g]) && (|map_reg[g])) : (|hit);
         assign tif.tick = tick_reg;
         assign tif.comb = comb[g];
         assign tif.pickup = pu_reg[g];
         assign tif.dropout = dr_reg[g];
         assign out_act[g] = tif.active;
         tol_delay_tmr u_tmr (
            .CLK(CLK),
            .RST_B(RST_B),
            .t(tif.tmr)
         );
      end
   endgenerate

   // contact sense
   wire logic [NUM_OUT-1:0] out_sense = {4'h0, ctrl_reg[CTRL_OUT2_NC], ctrl_reg[CTRL_OUT1_NC]};
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         trip_out_reg <= 1'b0;
         out_reg <= '0;
      end else begin
         trip_out_reg <= trip_reg ^ ctrl_reg[CTRL_TRIP_NC];
         out_reg <= out_act ^ out_sense;
      end
   end
   assign TRIP_CONTACT = trip_out_reg;
   assign OUT_CONTACT = out_reg;

   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   property p_trip_set;
      trip_set |=> trip_reg ##1 (TRIP_CONTACT != ctrl_reg[CTRL_TRIP_NC] || $past(ctrl_reg[1]) != ctrl_reg[1]);
   endproperty
   a_trip_set: assert property (p_trip_set) else $error("trip did not assert");

   property p_mask;
      $rose(trip_reg) |-> $past(|(ELEM_OP & mask_reg));
   endproperty
   a_mask: assert property (p_mask) else $error("masked element tripped");

   property p_release;
      ($fell(trip_reg) && !$past(mdt)) |-> $past(all_low && BREAKER_OPEN_AUX && !BREAKER_CLOSED_AUX);
   endproperty
   a_release: assert property (p_release) else $error("trip released early");

   property p_hold;
      (trip_reg && !mdt && !release_ok) |=> trip_reg;
   endproperty
   a_hold: assert property (p_hold) else $error("trip seal-in lost");

   property p_mdt;
      ($fell(trip_reg) && $past(mdt) && !$past(trip_set)) |->
         $past(mdt_cnt_reg) == MDT_CYCLES - 24'h00_0001;
   endproperty
   a_mdt: assert property (p_mdt) else $error("mdt release time wrong");

   property p_pin6;
      PIN_STATE[5] |-> $past(PIN_POS[5]) && $past(PIN6_NEG);
   endproperty
   a_pin6: assert property (p_pin6) else $error("input 6 high without both polarities");

   property p_func;
      $past(RST_B) |-> FUNC_EN == $past(FUNC_LOGIC);
   endproperty
   a_func: assert property (p_func) else $error("function enable mismatch");

   property p_sense;
      $past(RST_B) |-> OUT_CONTACT[5:2] == $past(out_act[5:2]);
   endproperty
   a_sense: assert property (p_sense) else $error("outputs 3-6 inverted");

   property p_gate_and;
      (gate_reg[0] && comb[0]) |-> ((LOGIC_SIG & map_reg[0]) == map_reg[0]);
   endproperty
   a_gate_and: assert property (p_gate_and) else $error("AND gate passed with input low");

   property p_gate_or;
      (!gate_reg[0] && |(LOGIC_SIG & map_reg[0])) |-> comb[0];
   endproperty
   a_gate_or: assert property (p_gate_or) else $error("OR gate blocked");

   sequence s_no_cause;
      !trip_reg && !(|(ELEM_OP & mask_reg));
   endsequence
   property p_masked;
      s_no_cause |=> !trip_reg;
   endproperty
   a_masked: assert property (p_masked) else $error("unmasked trip");

   sequence s_brk_shut;
      trip_reg && !mdt && (!BREAKER_OPEN_AUX || BREAKER_CLOSED_AUX);
   endsequence
   property p_aux_hold;
      s_brk_shut |=> trip_reg;
   endproperty
   a_aux_hold: assert property (p_aux_hold) else $error("breaker still shut");

   property p_mdt_hold;
      (trip_reg && mdt && !all_low) |=> trip_reg;
   endproperty
   a_mdt_hold: assert property (p_mdt_hold) else $error("mdt trip dropped early");

   property p_tick;
      tick_reg |=> (!tick_reg) [*8];
   endproperty
   a_tick: assert property (p_tick) else $error("tick too often");
endmodule

// ==== tol_pkg.sv ====
package tol_pkg;
   // clock and time base
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_MS = 10;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   // multiple device trip release delay, in power-system cycles
   localparam int LINE_HZ = 60;
   localparam int MDT_LINE_CYC = 3;
   localparam int MDT_CYC = CLK_HZ / LINE_HZ * MDT_LINE_CYC;
   // output timer range: 0 to 250 s in 10 ms steps
   localparam int DLY_MAX_S = 250;
   localparam int DLY_STEP_MS = 10;
   localparam int DLY_MAX_TICKS = DLY_MAX_S * 1000 / DLY_STEP_MS;
   // sizes
   localparam int NUM_ELEM = 9;
   localparam int NUM_OUT = 6;
   localparam int NUM_SIG = 16;
   localparam int NUM_PIN = 6;
   localparam int NUM_PHASE = 3;
   localparam int DLY_W = 15;
   localparam int CNT_W = 24;
   // element bit positions in the trip mask
   localparam int EL_TOC_PH = 0;
   localparam int EL_TOC_GND = 1;
   localparam int EL_IOC_PH1 = 2;
   localparam int EL_IOC_PH2 = 3;
   localparam int EL_IOC_PH3 = 4;
   localparam int EL_IOC_GND1 = 5;
   localparam int EL_IOC_GND2 = 6;
   localparam int EL_IOC_GND3 = 7;
   localparam int EL_NEG_SEQ = 8;
   // register byte offsets
   localparam logic [7:0] OFF_MASK = 8'h00;
   localparam logic [7:0] OFF_CTRL = 8'h04;
   localparam logic [7:0] OFF_GATE = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0C;
   localparam logic [2:0] GRP_FIXED = 3'h0;
   localparam logic [2:0] GRP_MAP = 3'h1;
   localparam logic [2:0] GRP_PICKUP = 3'h2;
   localparam logic [2:0] GRP_DROPOUT = 3'h3;
   // control register fields
   localparam int CTRL_MDT = 0;
   localparam int CTRL_TRIP_NC = 1;
   localparam int CTRL_OUT1_NC = 2;
   localparam int CTRL_OUT2_NC = 3;
   localparam int CTRL_W = 4;
   // reset values
   localparam logic [NUM_ELEM-1:0] MASK_RST = 9'h1FF;
   localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
   localparam logic [NUM_OUT-1:0] GATE_RST = 6'h00;
   localparam logic [NUM_SIG-1:0] MAP_RST = 16'h0000;
   localparam logic [DLY_W-1:0] DLY_RST = 15'h0000;

   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_READ = 1'b1
   } tol_bus_e;

   typedef enum logic [1:0] {
      TMR_OFF = 2'b00,
      TMR_PICK = 2'b01,
      TMR_ON = 2'b10,
      TMR_DROP = 2'b11
   } tol_tmr_e;
endpackage

// ==== tol_tmr_if.sv ====
`timescale 1ns/10ps
interface tol_tmr_if import tol_pkg::*; ();
   logic tick;
   logic comb;
   logic [DLY_W-1:0] pickup;
   logic [DLY_W-1:0] dropout;
   logic active;
   modport ctl (output tick, comb, pickup, dropout, input active);
   modport tmr (input tick, comb, pickup, dropout, output active);
endinterface

// ==== tol_delay_tmr.sv ====
`timescale 1ns/10ps
module tol_delay_tmr import tol_pkg::*; (
   input wire logic CLK,
   input wire logic RST_B,
   tol_tmr_if.tmr t
);
   tol_tmr_e state_reg;
   tol_tmr_e state_next;
   logic [DLY_W-1:0] cnt_reg;
   logic [DLY_W-1:0] cnt_next;

   wire logic [DLY_W-1:0] cnt_inc = cnt_reg + 15'h0001;
   wire logic pu_done = t.tick && (cnt_inc >= t.pickup);
   wire logic dr_done = t.tick && (cnt_inc >= t.dropout);

   // pickup and dropout sequencing
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      unique case (state_reg)
         TMR_OFF: begin
            cnt_next = '0;
            if (t.comb) begin
               state_next = (t.pickup == '0) ? TMR_ON : TMR_PICK;
            end
         end
         TMR_PICK: begin
            if (!t.comb) begin
               state_next = TMR_OFF;
            end else if (pu_done) begin
               state_next = TMR_ON;
            end else if (t.tick) begin
               cnt_next = cnt_inc;
            end
         end
         TMR_ON: begin
            cnt_next = '0;
            if (!t.comb) begin
               state_next = (t.dropout == '0) ? TMR_OFF : TMR_DROP;
            end
         end
         TMR_DROP: begin
            if (t.comb) begin
               state_next = TMR_ON;
            end else if (dr_done) begin
               state_next = TMR_OFF;
            end else if (t.tick) begin
               cnt_next = cnt_inc;
            end
         end
      endcase
   end

   // state and count
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         state_reg <= TMR_OFF;
         cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   assign t.active = state_reg[1];

   // checks
   property p_pick_restart;
      @(posedge CLK) disable iff (!RST_B)
      (state_reg == TMR_PICK && !t.comb) |=> (state_reg == TMR_OFF) && !t.active;
   endproperty
   a_pick_restart: assert property (p_pick_restart) else $error("pickup not restarted");

   property p_pick_tick;
      @(posedge CLK) disable iff (!RST_B)
      ($rose(t.active) && $past(t.pickup) != '0) |-> $past(t.tick && t.comb);
   endproperty
   a_pick_tick: assert property (p_pick_tick) else $error("output picked up early");

   sequence s_fall_with_delay;
      state_reg == TMR_ON && !t.comb && t.dropout != '0;
   endsequence
   property p_drop_hold;
      @(posedge CLK) disable iff (!RST_B)
      s_fall_with_delay |=> t.active && state_reg == TMR_DROP;
   endproperty
   a_drop_hold: assert property (p_drop_hold) else $error("dropout delay skipped");
endmodule

// ==== tol_brk_model.sv ====
`timescale 1ns/10ps
// breaker: opens a few cycles after the coil energises
module tol_brk_model #(
   parameter int OPEN_DLY = 4
) (
   input wire logic clk,
   input wire logic trip_contact,
   input wire logic nc,
   input wire logic stuck,
   input wire logic close_req,
   output logic closed_aux,
   output logic open_aux
);
   int cnt;
   logic coil;
   // contact sense undone before it reaches the coil
   assign coil = trip_contact ^ nc;
   // breaker starts closed
   initial begin
      cnt = 0;
      closed_aux = 1'b1;
      open_aux = 1'b0;
   end
   // aux contacts move one after the other, never both indicating
   always @(posedge clk) begin
      cnt <= (coil && !stuck) ? cnt + 1 : 0;
      if (cnt == OPEN_DLY) begin
         closed_aux <= 1'b0;
      end
      if (!closed_aux && !close_req) begin
         open_aux <= 1'b1;
      end
      if (close_req) begin
         open_aux <= 1'b0;
      end
      if (close_req && !open_aux) begin
         closed_aux <= 1'b1;
      end
   end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top import tol_pkg::*;;
   typedef struct {
      int sel;
      logic [31:0] exp;
   } tol_note_s;
   logic clk = 0, rst_b = 0, hsel = 0, hwrite = 0, neg6 = 0;
   logic stuck = 0, close = 0, nc = 0;
   logic hreadyout, trip, cl_aux, op_aux;
   logic [1:0] htrans = 0;
   logic [2:0] cur = 0;
   logic [5:0] pin = 0, pst, outc;
   logic [8:0] elem = 0, fl = 0, fen;
   logic [15:0] sig = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, lfsr = 32'h894f;
   int fail_count = 0, comparisons = 0;
   tol_note_s q[$];
   tol_note_s nt;
   event ev;
   string nm[5] = '{"trip", "out", "pins", "func_en", "rdata"};

   // short counts so the timers finish quickly
   tol_top #(.TICK_CYCLES(24'ha), .MDT_CYCLES(24'h14)) tol_top_inst (
      .CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(), .ELEM_OP(elem),
      .FUNC_LOGIC(fl), .CUR_LOW(cur), .BREAKER_CLOSED_AUX(cl_aux),
      .BREAKER_OPEN_AUX(op_aux), .PIN_POS(pin), .PIN6_NEG(neg6), .LOGIC_SIG(sig),
      .TRIP_CONTACT(trip), .OUT_CONTACT(outc), .PIN_STATE(pst), .FUNC_EN(fen));

   // far side of the trip contact
   tol_brk_model tol_brk_model_inst (
      .clk(clk), .trip_contact(trip), .nc(nc), .stuck(stuck),
      .close_req(close), .closed_aux(cl_aux), .open_aux(op_aux));

   // 20 MHz clock
   always #25 clk = ~clk;

   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction

   function automatic logic [31:0] seen(int s);
      case (s)
         0: return 32'(trip);
         1: return 32'(outc);
         2: return 32'(pst);
         3: return 32'(fen);
         default: return hrdata;
      endcase
   endfunction

   task automatic chk(string name, logic [31:0] got, logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic note(int sel, logic [31:0] exp);
      @(negedge clk);
      q.push_back('{sel, exp});
      ->ev;
   endtask

   task automatic cyc(int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic done(string s);
      $display("test %s finished", s);
   endtask

   // waits for hready, bounded
   task automatic rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 9);
      if (n >= 9) begin
         fail_count++;
      end
   endtask

   // one single word transfer, address phase then data phase
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      hsel <= 1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= 32'(a);
      rdy;
      hsel <= 0;
      htrans <= 0;
      hwdata <= d;
      rdy;
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d);
      bus(1, a, d);
   endtask

   task automatic rd(logic [7:0] a, logic [31:0] e);
      bus(0, a, 0);
      note(4, e);
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // watcher: compares each result with the oldest note
   initial forever begin
      @(ev);
      while (q.size() > 0) begin
         nt = q.pop_front();
         chk(nm[nt.sel], seen(nt.sel), nt.exp);
      end
   end

   // watchdog well beyond the expected run length
   initial begin
      cyc(20000);
      fail_count++;
      conclude;
   end

   // main sequence
   initial begin
      logic [8:0] b;
      logic [31:0] o;
      cyc(2);
      rst_b <= 1;
      rd(OFF_MASK, 32'h1ff);
      rd(OFF_CTRL, 0);
      rd(8'h1c, 0);
      wr(OFF_GATE, 32'hffff_ffea);
      rd(OFF_GATE, 32'h2a);
      wr(8'h44, 32'h0000_ffff);
      rd(8'h44, DLY_MAX_TICKS);
      done("registers");
      repeat (6) begin
         @(posedge clk);
         {neg6, pin} <= 7'(rnd());
         cyc(2);
         note(2, {pin[5] & neg6, pin[4:0]});
      end
      rd(OFF_STAT, 32'({pin[5] & neg6, pin[4:0]}) << 7);
      done("inputs");
      for (int i = 0; i < NUM_ELEM; i++) begin
         b = 9'(1 << i);
         @(posedge clk);
         fl <= ~b;
         @(posedge clk);
         elem <= b;
         cyc(4);
         note(3, 32'(9'(~b)));
         note(0, 0);
         wr(OFF_MASK, 32'(~b));
         fl <= '1;
         cyc(4);
         note(0, 0);
         wr(OFF_MASK, 32'h1ff);
         cyc(4);
         note(0, 1);
         @(posedge clk);
         elem <= 0;
         stuck <= 1;
         cur <= 3'h7;
         cyc(12);
         note(0, 1);
         @(posedge clk);
         stuck <= 0;
         cur <= 3'(rnd()) & ~3'(1 << (i % 3));
         cyc(12);
         note(0, 1);
         @(posedge clk);
         cur <= 3'h7;
         cyc(4);
         note(0, 0);
         @(posedge clk);
         close <= 1;
         cur <= 0;
         cyc(4);
         close <= 0;
      end
      done("trip latch");
      wr(OFF_CTRL, 32'he);
      nc <= 1;
      cyc(4);
      note(0, 1);
      note(1, 32'h3);
      wr(OFF_CTRL, 0);
      nc <= 0;
      done("contact sense");
      wr(OFF_CTRL, 32'h1);
      stuck <= 1;
      elem <= 9'h1;
      cyc(4);
      note(0, 1);
      @(posedge clk);
      elem <= 0;
      cur <= 3'h7;
      cyc(16);
      note(0, 1);
      cyc(8);
      note(0, 0);
      wr(OFF_CTRL, 0);
      stuck <= 0;
      cur <= 0;
      done("multi device");
      for (int n = 0; n < NUM_OUT; n++) begin
         wr(8'(8'h20 + 4 * n), 32'h3 << (2 * n));
         wr(8'(8'h40 + 4 * n), 3);
         wr(8'(8'h60 + 4 * n), 2);
      end
      for (int n = 0; n < NUM_OUT; n++) begin
         o = 32'(1 << n);
         @(posedge clk);
         sig <= 16'(1 << (2 * n));
         cyc(12);
         note(1, 0);
         cyc(36);
         note(1, n % 2 ? 0 : o);
         @(posedge clk);
         sig <= 16'(3 << (2 * n));
         cyc(48);
         note(1, o);
         @(posedge clk);
         sig <= 0;
         cyc(8);
         note(1, o);
         cyc(30);
         note(1, 0);
      end
      repeat (3) begin
         @(posedge clk);
         sig <= 16'h1;
         cyc(15);
         sig <= 0;
         cyc(2);
      end
      note(1, 0);
      done("outputs");
      conclude;
   end
endmodule
